/* File: verilog/strap_cfg_select.sv */
// Purpose: capture gpio straps at master reset release and run the start-up order
// Assumes: factory masks are stable before master_reset_n rises
// Notes: pins are sampled after synchronisation, so capture trails the pin edge
`timescale 1ns/1ps
`default_nettype none

module strap_cfg_select
    import strap_cfg_pkg::*;
#(
    parameter int NUM_GPIO = 10,
    parameter int SEL_W = 4,
    parameter int NUM_CLK_OUT = 12
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic reset_n, // async system reset, active low
    input wire logic master_reset_n, // master reset pin, active low
    input wire logic [NUM_GPIO-1:0] gpio_in, // gpio pin levels
    input wire logic info_programmed, // factory device info is programmed
    input wire logic [NUM_GPIO-1:0] sel_pin_mask, // pins used as selector
    input wire logic [NUM_GPIO-1:0] addr_pin_mask, // pins used as a2
    input wire logic [NUM_GPIO-1:0] eep_dis_pin_mask, // pins used as eeprom disable
    input wire logic host_wr, // host write pulse
    input wire logic host_proto_i2c, // host value for protocol
    input wire logic host_a2, // host value for a2
    input wire logic host_eep_search, // host value for eeprom search
    input wire logic otp_load_done, // stored config read finished
    input wire logic otp_checksum_ok, // stored config checksum good
    input wire logic otp_proto_i2c, // stored config protocol
    input wire logic otp_a2, // stored config a2
    input wire logic [NUM_CLK_OUT-1:0] otp_clk_out_en, // stored clock enables
    input wire logic [NUM_GPIO-1:0] otp_gpio_oe, // stored gpio output enables
    input wire logic regulators_ok, // regulators settled
    input wire logic clocks_ok, // internal clocks running
    input wire logic pll_locked, // analog pll locked to crystal
    input wire logic eeprom_done, // eeprom search finished
    output logic [NUM_GPIO-1:0] captured_gpio, // held strap levels
    output logic proto_i2c, // main port uses i2c
    output logic slave_a2, // i2c slave address bit a2
    output logic eeprom_search_en, // eeprom search allowed
    output logic [SEL_W-1:0] cfg_select, // stored configuration index
    output logic hold_pin_fault, // hold-high pin seen low
    output logic otp_load_req, // request stored config read
    output logic regulator_en, // enable regulators
    output logic clocks_en, // enable internal clocks
    output logic pll_cal_en, // calibrate and lock pll
    output logic eeprom_req, // request eeprom search
    output logic startup_done, // start-up finished
    output logic [NUM_CLK_OUT-1:0] clk_out_en, // clock output enables
    output logic [NUM_GPIO-1:0] gpio_oe // gpio output enables
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (NUM_GPIO <= GPIO_PROTO_IDX) begin : g_bad_gpio
        $error("NUM_GPIO too small for fixed strap pins");
    end
    if (SEL_W < DEF_SEL_W) begin : g_bad_sel
        $error("SEL_W narrower than default selector");
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    logic mr_s;
    logic [NUM_GPIO-1:0] gpio_s;

    // master reset starts asserted so no false release edge
    sync_2ff #(
        .W(1),
        .RESET_VAL(MR_ASSERTED)
    ) u_sync_mr (
        .clk(clk),
        .reset_n(reset_n),
        .d(master_reset_n),
        .q(mr_s)
    );

    // pins idle at the pull-up level
    sync_2ff #(
        .W(NUM_GPIO),
        .RESET_VAL({NUM_GPIO{GPIO_PULL_LEVEL}})
    ) u_sync_gpio (
        .clk(clk),
        .reset_n(reset_n),
        .d(gpio_in),
        .q(gpio_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // release edge

    logic mr_q_reg;
    logic mr_q_next;
    logic mr_rise;

    // pins and reset share one sync depth, so samples line up
    always_comb begin
        mr_q_next = mr_s;
        mr_rise = mr_s & ~mr_q_reg;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mr_q_reg <= MR_ASSERTED;
        end else begin
            mr_q_reg <= mr_q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap decode

    logic [NUM_GPIO-1:0] sel_m;
    logic [NUM_GPIO-1:0] addr_m;
    logic [NUM_GPIO-1:0] dis_m;
    logic [SEL_W-1:0] sel_v;
    logic a2_v;
    logic dis_v;
    logic i2c_v;

    // unprogrammed parts see no assigned roles
    always_comb begin
        int unsigned k;
        k = 0;
        sel_m = info_programmed ? sel_pin_mask : '0;
        addr_m = info_programmed ? addr_pin_mask : '0;
        dis_m = info_programmed ? eep_dis_pin_mask : '0;
        sel_v = '0;
        a2_v = A2_DEFAULT;
        i2c_v = gpio_s[GPIO_PROTO_IDX];
        dis_v = |(dis_m & gpio_s);
        if (sel_m == '0) begin
            // undriven pulled-up pins give index 15
            sel_v[DEF_SEL_W-1:0] = gpio_s[DEF_SEL_LSB +: DEF_SEL_W];
        end else begin
            // pack in index order; pins past SEL_W are dropped
            for (int i = 0; i < NUM_GPIO; i++) begin
                if (sel_m[i]) begin
                    if (k < SEL_W) begin
                        sel_v[k] = gpio_s[i];
                    end
                    k = k + 1;
                end
            end
        end
        // later pins overwrite, so the highest index wins
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (addr_m[i]) begin
                a2_v = gpio_s[i];
            end
        end
        if (i2c_v == PROTO_SPI) begin
            a2_v = A2_DEFAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // captured settings

    logic [NUM_GPIO-1:0] cap_reg;
    logic [NUM_GPIO-1:0] cap_next;
    logic i2c_reg;
    logic i2c_next;
    logic a2_reg;
    logic a2_next;
    logic eep_reg;
    logic eep_next;
    logic [SEL_W-1:0] sel_reg;
    logic [SEL_W-1:0] sel_next;
    logic fault_reg;
    logic fault_next;
    logic otp_apply;

    // capture beats host write; host and stored config may overwrite later
    always_comb begin
        cap_next = cap_reg;
        i2c_next = i2c_reg;
        a2_next = a2_reg;
        eep_next = eep_reg;
        sel_next = sel_reg;
        fault_next = fault_reg;
        if (mr_rise) begin
            cap_next = gpio_s;
            i2c_next = i2c_v;
            a2_next = a2_v;
            eep_next = ~dis_v & (i2c_v == PROTO_I2C);
            sel_next = sel_v;
            fault_next = ~gpio_s[GPIO_HOLD_HIGH_IDX];
        end else if (host_wr) begin
            i2c_next = host_proto_i2c;
            a2_next = host_a2;
            eep_next = host_eep_search & (host_proto_i2c == PROTO_I2C);
        end else if (otp_apply) begin
            i2c_next = otp_proto_i2c;
            a2_next = otp_a2;
            // a stored switch to spi takes the i2c master pins away
            eep_next = eep_reg & (otp_proto_i2c == PROTO_I2C);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_reg <= {NUM_GPIO{GPIO_PULL_LEVEL}};
            i2c_reg <= PROTO_RESET;
            a2_reg <= A2_DEFAULT;
            eep_reg <= EEP_SEARCH_RESET;
            sel_reg <= '0;
            fault_reg <= 1'b0;
        end else begin
            cap_reg <= cap_next;
            i2c_reg <= i2c_next;
            a2_reg <= a2_next;
            eep_reg <= eep_next;
            sel_reg <= sel_next;
            fault_reg <= fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up sequencer

    seq_state_e state_reg;
    seq_state_e state_next;
    logic load_reg;
    logic load_next;
    logic reg_en_reg;
    logic reg_en_next;
    logic clk_en_reg;
    logic clk_en_next;
    logic pll_reg;
    logic pll_next;
    logic eep_req_reg;
    logic eep_req_next;
    logic done_reg;
    logic done_next;
    logic [NUM_CLK_OUT-1:0] cko_reg;
    logic [NUM_CLK_OUT-1:0] cko_next;
    logic [NUM_GPIO-1:0] oe_reg;
    logic [NUM_GPIO-1:0] oe_next;

    // enables stay on once a step is reached; master reset drops them all
    always_comb begin
        state_next = state_reg;
        load_next = 1'b0;
        reg_en_next = reg_en_reg;
        clk_en_next = clk_en_reg;
        pll_next = pll_reg;
        eep_req_next = 1'b0;
        done_next = done_reg;
        cko_next = cko_reg;
        oe_next = oe_reg;
        otp_apply = 1'b0;
        unique case (state_reg)
            ST_HOLD: begin
                if (mr_rise) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // unprogrammed parts have no stored config to read
                if (!info_programmed) begin
                    state_next = ST_REG;
                end else begin
                    load_next = ~otp_load_done;
                    if (otp_load_done) begin
                        otp_apply = otp_checksum_ok;
                        if (otp_checksum_ok) begin
                            cko_next = otp_clk_out_en;
                            oe_next = otp_gpio_oe;
                        end
                        state_next = ST_REG;
                    end
                end
            end
            ST_REG: begin
                reg_en_next = 1'b1;
                if (reg_en_reg && regulators_ok) begin
                    state_next = ST_CLK;
                end
            end
            ST_CLK: begin
                clk_en_next = 1'b1;
                if (clk_en_reg && clocks_ok) begin
                    state_next = ST_PLL;
                end
            end
            ST_PLL: begin
                pll_next = 1'b1;
                if (pll_reg && pll_locked) begin
                    state_next = ST_EEP;
                end
            end
            ST_EEP: begin
                if (!eep_reg) begin
                    state_next = ST_DONE;
                end else begin
                    eep_req_next = ~eeprom_done;
                    if (eeprom_done) begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                done_next = 1'b1;
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        if (!mr_s) begin
            // back to defaults: outputs off, pins as inputs
            state_next = ST_HOLD;
            load_next = 1'b0;
            reg_en_next = 1'b0;
            clk_en_next = 1'b0;
            pll_next = 1'b0;
            eep_req_next = 1'b0;
            done_next = 1'b0;
            cko_next = {NUM_CLK_OUT{CLK_OUT_EN_RESET}};
            oe_next = {NUM_GPIO{GPIO_OE_RESET}};
            otp_apply = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_HOLD;
            load_reg <= 1'b0;
            reg_en_reg <= 1'b0;
            clk_en_reg <= 1'b0;
            pll_reg <= 1'b0;
            eep_req_reg <= 1'b0;
            done_reg <= 1'b0;
            cko_reg <= {NUM_CLK_OUT{CLK_OUT_EN_RESET}};
            oe_reg <= {NUM_GPIO{GPIO_OE_RESET}};
        end else begin
            state_reg <= state_next;
            load_reg <= load_next;
            reg_en_reg <= reg_en_next;
            clk_en_reg <= clk_en_next;
            pll_reg <= pll_next;
            eep_req_reg <= eep_req_next;
            done_reg <= done_next;
            cko_reg <= cko_next;
            oe_reg <= oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops

    assign captured_gpio = cap_reg;
    assign proto_i2c = i2c_reg;
    assign slave_a2 = a2_reg;
    assign eeprom_search_en = eep_reg;
    assign cfg_select = sel_reg;
    assign hold_pin_fault = fault_reg;
    assign otp_load_req = load_reg;
    assign regulator_en = reg_en_reg;
    assign clocks_en = clk_en_reg;
    assign pll_cal_en = pll_reg;
    assign eeprom_req = eep_req_reg;
    assign startup_done = done_reg;
    assign clk_out_en = cko_reg;
    assign gpio_oe = oe_reg;

endmodule

`default_nettype wire

/* File: verilog/strap_cfg_pkg.sv */
// Purpose: shared constants and state codes for the reset strap configuration loader
// Assumes: gpio numbering starts at 0; pins are pulled up when nobody drives them
// Notes: timing of the start-up steps is set by handshakes, so no counts live here
//
// Behaviour
// - capture every gpio level at the rising edge of master_reset_n; derive start-up setup
// - captured gpio 9: low selects spi, high selects i2c on the main port
// - no selector pins assigned: gpio 3..0 form the configuration selector
// - undriven pulled-up selector pins select stored configuration 15
// - selector bits follow pin index order, lowest index is lsb, gaps allowed
// - under four selector pins: low bits used, upper bits of four forced zero
// - over four selector pins: only the SEL_W lowest-indexed ones are used, the rest are dropped
// - no address pin assigned: i2c slave address bit a2 is zero
// - several address pins: only the highest-indexed one gives a2
// - address pin has no effect when spi is captured
// - high on an eeprom-disable pin blocks eeprom reads at start-up
// - no eeprom-disable pin assigned: search for an eeprom whenever i2c is captured
// - several eeprom-disable pins: any one high disables (or)
// - pin roles come from factory device info; unprogrammed parts keep defaults
// - protocol, a2 and eeprom search stay writable by later load or host access; selector and captured pins do not
// - register defaults: all clock outputs off, all gpio plain inputs
// - sequence: load config, enable regulators, clocks, calibrate and lock pll
// - selector chooses the stored configuration; no effect on unprogrammed parts
// - stored configuration failing checksum is skipped; registers stay default
// - eeprom search skipped whenever the main port is spi
package strap_cfg_pkg;

    // pin roles fixed by the package pinout
    localparam int GPIO_PROTO_IDX = 9;
    localparam int GPIO_HOLD_HIGH_IDX = 8;
    localparam int DEF_SEL_LSB = 0;
    localparam int DEF_SEL_W = 4;

    // protocol encodings of the captured select pin
    localparam logic PROTO_SPI = 1'b0;
    localparam logic PROTO_I2C = 1'b1;

    // reset values of derived settings
    localparam logic A2_DEFAULT = 1'b0;
    localparam logic PROTO_RESET = PROTO_I2C;
    localparam logic EEP_SEARCH_RESET = 1'b0;
    localparam logic CLK_OUT_EN_RESET = 1'b0;
    localparam logic GPIO_OE_RESET = 1'b0;
    localparam logic GPIO_PULL_LEVEL = 1'b1;
    localparam logic MR_ASSERTED = 1'b0;

    // start-up sequencer, one-hot
    typedef enum logic [6:0] {
        ST_HOLD = 7'h01,
        ST_LOAD = 7'h02,
        ST_REG = 7'h04,
        ST_CLK = 7'h08,
        ST_PLL = 7'h10,
        ST_EEP = 7'h20,
        ST_DONE = 7'h40
    } seq_state_e;

endpackage

/* File: verilog/sync_2ff.sv */
// Purpose: two flip-flop synchroniser for a bundle of asynchronous levels
// Assumes: each bit is a slow level; bits are not coherent with each other
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous input
    output logic [W-1:0] q // synchronised output
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // two stages, nothing reads the first except the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule

`default_nettype wire

/* File: sim/strap_cfg_select_sva.sv */
// Purpose: concurrent checks on strap capture, host writes and start-up order
// Assumes: host writes are kept away from capture and stored loads
// Notes: a fresh capture is seen from outside as the first start-up request
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module strap_cfg_select_chk
    import strap_cfg_pkg::*;
#(
    parameter int NUM_GPIO = 10,
    parameter int NUM_CLK_OUT = 12
) (
    input wire logic clk, // clock
    input wire logic reset_n, // reset
    input wire logic master_reset_n, // master reset pin
    input wire logic info_programmed, // roles valid
    input wire logic [NUM_GPIO-1:0] eep_dis_pin_mask, // disable pins
    input wire logic host_wr, // host write
    input wire logic host_proto_i2c, // host proto
    input wire logic host_a2, // host a2
    input wire logic host_eep_search, // host search
    input wire logic otp_load_done, // load done
    input wire logic otp_checksum_ok, // checksum good
    input wire logic [NUM_GPIO-1:0] captured_gpio, // held pins
    input wire logic proto_i2c, // protocol
    input wire logic slave_a2, // a2
    input wire logic eeprom_search_en, // search on
    input wire logic otp_load_req, // load request
    input wire logic regulator_en, // regulators
    input wire logic clocks_en, // clocks
    input wire logic pll_cal_en, // pll
    input wire logic eeprom_req, // eeprom request
    input wire logic startup_done, // done
    input wire logic [NUM_CLK_OUT-1:0] clk_out_en, // clock enables
    input wire logic [NUM_GPIO-1:0] gpio_oe // pin enables
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // role masks count only on programmed parts
    wire logic [NUM_GPIO-1:0] dis_eff = eep_dis_pin_mask & {NUM_GPIO{info_programmed}};

    // first start-up request after a capture, no host write just before
    sequence fresh;
        ($rose(otp_load_req) || ($rose(regulator_en) && !info_programmed)) && !$past(host_wr);
    endsequence

    a_proto_pin9: assert property (fresh |->
        proto_i2c == captured_gpio[GPIO_PROTO_IDX])
        else $error("protocol not from pin 9");
    a_spi_no_a2: assert property (fresh |-> proto_i2c || !slave_a2)
        else $error("a2 set under spi");
    a_eep_or: assert property (fresh |->
        eeprom_search_en == (proto_i2c && (dis_eff & captured_gpio) == '0))
        else $error("eeprom search wrong");
    a_host_write: assert property (host_wr |=> proto_i2c == $past(host_proto_i2c) &&
        slave_a2 == $past(host_a2) &&
        eeprom_search_en == $past(host_eep_search && host_proto_i2c))
        else $error("host write lost");
    a_load_to_reg: assert property (otp_load_req && otp_load_done |->
        ##[1:2] regulator_en)
        else $error("regulators late");
    a_order_clk: assert property ($rose(clocks_en) |-> regulator_en)
        else $error("clocks before regulators");
    a_order_pll: assert property ($rose(pll_cal_en) |-> clocks_en)
        else $error("pll before clocks");
    a_done_last: assert property ($rose(startup_done) |-> pll_cal_en && !eeprom_req)
        else $error("done too early");
    a_bad_sum: assert property (otp_load_req && otp_load_done && !otp_checksum_ok |=>
        (clk_out_en == '0 && gpio_oe == '0) [*3])
        else $error("bad stored config applied");
    a_mr_defaults: assert property (!master_reset_n [*6] |->
        clk_out_en == '0 && gpio_oe == '0 && !startup_done)
        else $error("enables on in master reset");
    a_hold_caps: assert property (!master_reset_n |=> $stable(captured_gpio))
        else $error("captured pins moved");

    // main scenarios reached
    c_eeprom: cover property ($rose(eeprom_req));
    c_bad_sum: cover property (otp_load_done && !otp_checksum_ok && otp_load_req);
    c_host_b2b: cover property (host_wr ##1 host_wr);
endmodule

bind strap_cfg_select strap_cfg_select_chk #(.NUM_GPIO(NUM_GPIO), .NUM_CLK_OUT(NUM_CLK_OUT))
    strap_cfg_select_chk_i (.clk, .reset_n, .master_reset_n, .info_programmed, .eep_dis_pin_mask,
    .host_wr, .host_proto_i2c, .host_a2, .host_eep_search, .otp_load_done, .otp_checksum_ok,
    .captured_gpio, .proto_i2c, .slave_a2, .eeprom_search_en, .otp_load_req, .regulator_en,
    .clocks_en, .pll_cal_en, .eeprom_req, .startup_done, .clk_out_en, .gpio_oe);
`default_nettype wire

/* File: sim/strap_board.sv */
// Purpose: board model with strap resistors, master reset driver and start-up responders
// Assumes: pins left undriven float to the pull-up level
// Notes: each answer comes lag cycles after its request and drops with it
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module strap_board (
    input wire logic clk, // clock
    input wire logic reset_n, // reset, active low
    input wire logic mr_assert, // hold master reset
    input wire logic [9:0] strap_val, // strap levels
    input wire logic [9:0] strap_drv, // pins driven by straps
    input wire logic [7:0] lag, // answer delay in cycles
    input wire logic [4:0] req, // start-up requests, load first
    output logic master_reset_n, // master reset pin
    output logic [9:0] gpio_in, // pin levels
    output logic [4:0] ack // start-up answers
);
    logic [7:0] cnt [5];

    // pull-up wins on undriven pins; pin 8 stays high through reset
    assign gpio_in = strap_val | ~strap_drv | 10'h100;
    assign master_reset_n = !mr_assert;

    // a lag of zero answers at once, larger lags stall the sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++) begin
                cnt[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (!req[i]) begin
                    cnt[i] <= 8'h00;
                end else if (cnt[i] != 8'hff) begin
                    cnt[i] <= cnt[i] + 8'h01;
                end
            end
        end
    end

    // answers fall as soon as the request goes away
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            ack[i] = req[i] && cnt[i] >= lag;
        end
    end
endmodule
`default_nettype wire

/* File: sim/test_strap_cfg_select.sv */
// Purpose: directed start-up runs of the strap loader against the board model
// Assumes: stored config data is set once and only the checksum changes
// Notes: host writes stay clear of capture and stored loads
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module test_strap_cfg_select;
    import strap_cfg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic mr_assert = 1'b1;
    logic info_programmed = 1'b0;
    logic host_wr = 1'b0;
    logic host_proto_i2c = 1'b0;
    logic host_a2 = 1'b0;
    logic host_eep_search = 1'b0;
    logic otp_checksum_ok = 1'b0;
    logic otp_proto_i2c = 1'b0;
    logic otp_a2 = 1'b1;
    logic [9:0] strap_val = '0, strap_drv = '0, sel_pin_mask = '0, addr_pin_mask = '0;
    logic [9:0] eep_dis_pin_mask = '0, otp_gpio_oe = 10'h3ff;
    logic [11:0] otp_clk_out_en = 12'hfff;
    logic [7:0] lag = 8'h00;
    int mismatches = 0;
    int total_checks = 0;
    wire logic master_reset_n, otp_load_done, regulators_ok, clocks_ok, pll_locked, eeprom_done;
    wire logic proto_i2c, slave_a2, eeprom_search_en, hold_pin_fault, otp_load_req;
    wire logic regulator_en, clocks_en, pll_cal_en, eeprom_req, startup_done;
    wire logic [9:0] gpio_in, captured_gpio, gpio_oe;
    wire logic [3:0] cfg_select;
    wire logic [11:0] clk_out_en;
    wire logic [1:0] stat = {startup_done, otp_load_req | regulator_en};

    strap_cfg_select strap_cfg_select_i (.clk, .reset_n, .master_reset_n, .gpio_in,
        .info_programmed, .sel_pin_mask, .addr_pin_mask, .eep_dis_pin_mask, .host_wr,
        .host_proto_i2c, .host_a2, .host_eep_search, .otp_load_done, .otp_checksum_ok,
        .otp_proto_i2c, .otp_a2, .otp_clk_out_en, .otp_gpio_oe, .regulators_ok, .clocks_ok,
        .pll_locked, .eeprom_done, .captured_gpio, .proto_i2c, .slave_a2, .eeprom_search_en,
        .cfg_select, .hold_pin_fault, .otp_load_req, .regulator_en, .clocks_en, .pll_cal_en,
        .eeprom_req, .startup_done, .clk_out_en, .gpio_oe);
    strap_board strap_board_i (.clk, .reset_n, .mr_assert, .strap_val, .strap_drv, .lag,
        .req({eeprom_req, pll_cal_en, clocks_en, regulator_en, otp_load_req}), .master_reset_n,
        .gpio_in, .ack({eeprom_done, pll_locked, clocks_ok, regulators_ok, otp_load_done}));

    // free-running clock
    always #10 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bounded wait so a stuck sequencer is reported, not hung on
    task automatic till(input int k);
        int n;
        n = 0;
        while (stat[k] !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n < 100), 16'h1);
    endtask

    // master reset pulse with new straps and roles, then wait for capture
    task automatic boot(input logic [9:0] v, d, s, a, e, input logic p, k, input logic [7:0] lg);
        logic [9:0] old;
        old = captured_gpio;
        @(posedge clk);
        mr_assert <= 1'b1;
        {strap_val, strap_drv, sel_pin_mask, addr_pin_mask, eep_dis_pin_mask} <= {v, d, s, a, e};
        {info_programmed, otp_checksum_ok, lag} <= {p, k, lg};
        repeat (7) @(posedge clk);
        #1;
        chk(16'(captured_gpio), 16'(old));
        chk(16'(|{clk_out_en, gpio_oe, startup_done}), 16'h0);
        @(posedge clk);
        mr_assert <= 1'b0;
        till(0);
    endtask

    // watchdog well past the longest expected run
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // unprogrammed part, straps floating: roles ignored, pull-ups give 15
        boot(10'h000, 10'h000, 10'h124, 10'h080, 10'h010, 1'b0, 1'b0, 8'h02);
        chk(16'(captured_gpio), 16'h3ff);
        chk(16'(cfg_select), 16'hf);
        chk(16'({proto_i2c, slave_a2, eeprom_search_en, otp_load_req}),
            16'ha);
        till(1);
        chk(16'(|{clk_out_en, gpio_oe}), 16'h0);
        // scattered selector pins, two address pins, two disable pins, bad checksum
        boot(10'h35c, 10'h3ff, 10'h164, 10'h088, 10'h012, 1'b1, 1'b0, 8'h00);
        chk(16'(captured_gpio), 16'h35c);
        chk(16'(cfg_select), 16'hd);
        chk(16'({proto_i2c, slave_a2, eeprom_search_en}),
            16'h4);
        till(1);
        chk(16'({proto_i2c, slave_a2, |clk_out_en, |gpio_oe}), 16'h8);
        // two selector pins, spi, good checksum, slow answers
        boot(10'h18a, 10'h3ff, 10'h082, 10'h008, 10'h000, 1'b1, 1'b1, 8'h05);
        chk(16'(cfg_select), 16'h3);
        chk(16'({proto_i2c, slave_a2, eeprom_search_en}), 16'h0);
        till(1);
        chk(16'({proto_i2c, slave_a2}), 16'h1);
        chk(16'(clk_out_en), 16'hfff);
        chk(16'(gpio_oe), 16'h3ff);
        // back-to-back host writes; second picks spi so search is forced off
        @(posedge clk);
        host_wr <= 1'b1;
        {host_proto_i2c, host_a2, host_eep_search} <= 3'b111;
        @(posedge clk);
        {host_proto_i2c, host_a2, host_eep_search} <= 3'b011;
        #1;
        chk(16'({proto_i2c, slave_a2, eeprom_search_en}), 16'h7);
        @(posedge clk);
        host_wr <= 1'b0;
        #1;
        chk(16'({proto_i2c, slave_a2, eeprom_search_en, cfg_select}),
            16'h23);
        // no roles assigned on a programmed part: default selector pins
        boot(10'h205, 10'h3ff, 10'h000, 10'h000, 10'h000, 1'b1, 1'b1, 8'h01);
        chk(16'(captured_gpio), 16'h305);
        chk(16'({cfg_select, proto_i2c, slave_a2, eeprom_search_en}),
            16'h2d);
        till(1);
        // stored config picked spi, so the search must be off; pin 8 held high
        chk(16'({eeprom_search_en, hold_pin_fault}), 16'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
